// [design/axi_chip_link_bridge_ports.v]
// Chip link bridge ports: link pins, link detect, status, interrupts and write address issue
//
// How it works
// - drive forwarded clock with full-width transmit bus
// - peer forwards clock; capture receive data on it
// - link up only in synchronized detect state
// - peer reset during normal operation raises irq
// - multibit fault irq when either core corrupts
// - multibit error during deskew means deskew failed
// - independent mode clocks interface from external clock
// - common mode ignores external interface clock input
// - common mode generates and outputs interface clock
// - global reset active low, asynchronous assertion tolerated
// - write identifier width configurable one to six
// - issue 32-bit first-beat write address only
// - carry four interrupt levels each direction
`include "bridge_defs.vh"

module axi_chip_link_bridge_ports #(
  parameter PHY_W = 8,
  parameter ID_W = 6,
  parameter CLK_MODE_COMMON = 1,
  parameter [7:0] LINK_HALF = `LINK_HALF_CYC,
  parameter [7:0] ACLK_HALF = `ACLK_HALF_CYC,
  parameter [7:0] DESKEW_GOOD = `DESKEW_GOOD_CNT
)(
  // Clock and resets
  input wire core_clk_in,
  input wire reset_n_in,
  input wire glob_rst_n_in,
  // Link pins
  output wire link_fwd_clk_out,
  output wire [PHY_W-1:0] link_tx_bus_out,
  input wire link_fwd_clk_in,
  input wire [PHY_W-1:0] link_rx_bus_in,
  // Status and interrupts
  output wire link_up_flag_out,
  output wire peer_reset_irq_out,
  input wire peer_reset_clr_in,
  output wire multibit_fault_irq_out,
  input wire [`IRQ_W-1:0] fwd_irq_in,
  output wire [`IRQ_W-1:0] rev_irq_out,
  // Master interface clocking
  input wire aclk_in,
  output wire aclk_out,
  // Write address channel
  output wire [ID_W-1:0] m_axi_awid_out,
  output wire [`ADDR_W-1:0] m_axi_awaddr_out,
  output wire m_axi_awvalid_out,
  input wire m_axi_awready_in
);

  // Number of differing bits between two symbols
  function [3:0] bit_dist;
    input [`SYM_W-1:0] a;
    input [`SYM_W-1:0] b;
    integer i;
    reg [`SYM_W-1:0] x;
    begin
      x = a ^ b;
      bit_dist = 4'h0;
      for (i = 0; i < `SYM_W; i = i + 1)
      begin
        bit_dist = bit_dist + {3'h0, x[i]};
      end
    end
  endfunction

  // Global reset: asserts at once, releases through two flops
  reg grst_s1_r;
  reg grst_s2_r;
  wire rst_n;

  always @(posedge core_clk_in or negedge glob_rst_n_in)
  begin
    if (!glob_rst_n_in)
    begin
      grst_s1_r <= 1'b0;
      grst_s2_r <= 1'b0;
    end
    else
    begin
      grst_s1_r <= 1'b1;
      grst_s2_r <= grst_s1_r;
    end
  end

  assign rst_n = reset_n_in & grst_s2_r;

  // Pin synchronisers
  reg [`IRQ_W-1:0] irq_s1_r;
  reg [`IRQ_W-1:0] irq_s2_r;
  reg awr_s1_r;
  reg awr_s2_r;
  reg ack_s1_r;
  reg ack_s2_r;
  reg ack_s3_r;
  reg aclk_gen_r;
  reg [7:0] aclk_cnt_r;
  wire aclk_src;
  wire aclk_tick;

  // Interface clock source depends on clocking mode
  assign aclk_src = (CLK_MODE_COMMON != 0) ? aclk_gen_r : aclk_in;
  assign aclk_tick = ack_s2_r & ~ack_s3_r;

  always @(posedge core_clk_in)
  begin
    if (!rst_n)
    begin
      irq_s1_r <= {`IRQ_W{1'b0}};
      irq_s2_r <= {`IRQ_W{1'b0}};
      awr_s1_r <= 1'b0;
      awr_s2_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
      aclk_gen_r <= 1'b0;
      aclk_cnt_r <= 8'h00;
    end
    else
    begin
      irq_s1_r <= fwd_irq_in;
      irq_s2_r <= irq_s1_r;
      awr_s1_r <= m_axi_awready_in;
      awr_s2_r <= awr_s1_r;
      ack_s1_r <= aclk_src;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      if (CLK_MODE_COMMON != 0)
      begin
        if (aclk_cnt_r == ACLK_HALF - 8'h01)
        begin
          aclk_cnt_r <= 8'h00;
          aclk_gen_r <= ~aclk_gen_r;
        end
        else
        begin
          aclk_cnt_r <= aclk_cnt_r + 8'h01;
        end
      end
    end
  end

  // Receive side
  wire [PHY_W-1:0] rx_beat;
  wire rx_stb;
  wire [`SYM_W-1:0] rx_sym;
  wire [1:0] rx_kind;
  wire [3:0] dist_seek;
  wire [3:0] dist_ack;
  wire [3:0] dist_min;

  link_rx_capture #(
    .PHY_W(PHY_W)
  ) u_rx (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .fwd_clk_in(link_fwd_clk_in),
    .rx_bus_in(link_rx_bus_in),
    .beat_out(rx_beat),
    .beat_stb_out(rx_stb)
  );

  assign rx_sym = rx_beat[`SYM_W-1:0];
  assign rx_kind = rx_sym[`KIND_MSB:`KIND_LSB];
  assign dist_seek = bit_dist(rx_sym, `TRAIN_SEEK);
  assign dist_ack = bit_dist(rx_sym, `TRAIN_ACK);
  assign dist_min = (dist_seek < dist_ack) ? dist_seek : dist_ack;

  // Link detect state machine
  localparam [3:0] ST_SEEK = `ST_SEEK;
  localparam [3:0] ST_DESKEW = `ST_DESKEW;
  localparam [3:0] ST_ACK = `ST_ACK;
  localparam [3:0] ST_SYNC = `ST_SYNC;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [7:0] good_cnt_r;
  reg [7:0] good_cnt_nxt;
  reg deskew_fail;
  reg peer_restart;

  always @*
  begin
    state_nxt = state_r;
    good_cnt_nxt = good_cnt_r;
    deskew_fail = 1'b0;
    peer_restart = 1'b0;
    case (state_r)
      ST_SEEK:
      begin
        good_cnt_nxt = 8'h00;
        if (rx_stb && dist_min == 4'h0)
        begin
          state_nxt = ST_DESKEW;
        end
      end
      ST_DESKEW:
      begin
        if (rx_stb)
        begin
          if (dist_min == 4'h0)
          begin
            good_cnt_nxt = good_cnt_r + 8'h01;
            if (good_cnt_r == DESKEW_GOOD - 8'h01)
            begin
              state_nxt = ST_ACK;
            end
          end
          else if (dist_min > 4'h1)
          begin
            // Several corrupted bits: deskew failed, start again
            deskew_fail = 1'b1;
            state_nxt = ST_SEEK;
          end
        end
      end
      ST_ACK:
      begin
        if (rx_stb && (rx_sym == `TRAIN_ACK || rx_kind == `KIND_STAT))
        begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC:
      begin
        // A seek pattern in normal operation means the peer was reset
        if (rx_stb && rx_sym == `TRAIN_SEEK)
        begin
          peer_restart = 1'b1;
          state_nxt = ST_SEEK;
        end
      end
      default:
      begin
        state_nxt = ST_SEEK;
      end
    endcase
  end

  // Status flags
  reg link_up_r;
  reg pr_irq_r;
  reg local_fault_r;
  reg peer_fault_r;
  reg mb_irq_r;
  reg [`IRQ_W-1:0] rev_irq_r;
  wire local_fault_nxt;
  wire stat_stb;

  assign stat_stb = rx_stb && state_r == ST_SYNC && rx_kind == `KIND_STAT;
  assign local_fault_nxt = deskew_fail | (local_fault_r & state_nxt != ST_SYNC);

  always @(posedge core_clk_in)
  begin
    if (!rst_n)
    begin
      state_r <= ST_SEEK;
      good_cnt_r <= 8'h00;
      link_up_r <= 1'b0;
      pr_irq_r <= 1'b0;
      local_fault_r <= 1'b0;
      peer_fault_r <= 1'b0;
      mb_irq_r <= 1'b0;
      rev_irq_r <= {`IRQ_W{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      good_cnt_r <= good_cnt_nxt;
      link_up_r <= (state_nxt == ST_SYNC);
      // Set wins over a clear in the same cycle
      if (peer_restart)
      begin
        pr_irq_r <= 1'b1;
      end
      else if (peer_reset_clr_in)
      begin
        pr_irq_r <= 1'b0;
      end
      local_fault_r <= local_fault_nxt;
      if (state_nxt != ST_SYNC)
      begin
        peer_fault_r <= 1'b0;
        rev_irq_r <= {`IRQ_W{1'b0}};
      end
      else if (stat_stb)
      begin
        peer_fault_r <= rx_sym[`STAT_FAULT_BIT];
        rev_irq_r <= rx_sym[`STAT_IRQ_MSB:`STAT_IRQ_LSB];
      end
      mb_irq_r <= local_fault_nxt | (stat_stb ? rx_sym[`STAT_FAULT_BIT] : peer_fault_r);
    end
  end

  // Write address assembly and issue
  reg coll_r;
  reg pend_r;
  reg [3:0] nib_cnt_r;
  reg [`ADDR_W-1:0] asm_addr_r;
  reg [ID_W-1:0] asm_id_r;
  reg awvalid_r;
  reg [`ADDR_W-1:0] awaddr_r;
  reg [ID_W-1:0] awid_r;
  wire busy;
  wire sync_stb;

  assign busy = coll_r | pend_r | awvalid_r;
  assign sync_stb = rx_stb && state_r == ST_SYNC;

  always @(posedge core_clk_in)
  begin
    if (!rst_n)
    begin
      coll_r <= 1'b0;
      pend_r <= 1'b0;
      nib_cnt_r <= 4'h0;
      asm_addr_r <= {`ADDR_W{1'b0}};
      asm_id_r <= {ID_W{1'b0}};
      awvalid_r <= 1'b0;
      awaddr_r <= {`ADDR_W{1'b0}};
      awid_r <= {ID_W{1'b0}};
    end
    else
    begin
      if (state_nxt != ST_SYNC)
      begin
        coll_r <= 1'b0;
        pend_r <= 1'b0;
      end
      else if (sync_stb && rx_kind == `KIND_ASTART && !pend_r && !awvalid_r)
      begin
        coll_r <= 1'b1;
        nib_cnt_r <= 4'h0;
        asm_id_r <= rx_sym[ID_W-1:0];
      end
      else if (sync_stb && rx_kind == `KIND_ANIB && coll_r)
      begin
        // First-beat address arrives most significant nibble first
        asm_addr_r <= {asm_addr_r[`ADDR_W-5:0], rx_sym[`NIB_MSB:0]};
        nib_cnt_r <= nib_cnt_r + 4'h1;
        if (nib_cnt_r == `ADDR_NIBBLES - 1)
        begin
          coll_r <= 1'b0;
          pend_r <= 1'b1;
        end
      end
      // Interface handshake is sampled on interface clock rises
      if (aclk_tick)
      begin
        if (awvalid_r && awr_s2_r)
        begin
          awvalid_r <= 1'b0;
        end
        else if (!awvalid_r && pend_r && state_nxt == ST_SYNC)
        begin
          awvalid_r <= 1'b1;
          awaddr_r <= asm_addr_r;
          awid_r <= asm_id_r;
          pend_r <= 1'b0;
        end
      end
    end
  end

  // Transmit side: forwarded clock and beats changing on its falling edge
  reg [7:0] lnk_cnt_r;
  reg fwd_clk_r;
  reg [PHY_W-1:0] tx_bus_r;
  reg [`SYM_W-1:0] tx_sym;

  always @*
  begin
    tx_sym = `TRAIN_SEEK;
    if (state_r == ST_SYNC)
    begin
      tx_sym = {`KIND_STAT, busy, local_fault_r, irq_s2_r};
    end
    else if (state_r == ST_ACK)
    begin
      tx_sym = `TRAIN_ACK;
    end
  end

  always @(posedge core_clk_in)
  begin
    if (!rst_n)
    begin
      lnk_cnt_r <= 8'h00;
      fwd_clk_r <= 1'b0;
      tx_bus_r <= {PHY_W{1'b0}};
    end
    else if (lnk_cnt_r == LINK_HALF - 8'h01)
    begin
      lnk_cnt_r <= 8'h00;
      fwd_clk_r <= ~fwd_clk_r;
      if (fwd_clk_r)
      begin
        tx_bus_r <= {PHY_W{1'b0}};
        tx_bus_r[`SYM_W-1:0] <= tx_sym;
      end
    end
    else
    begin
      lnk_cnt_r <= lnk_cnt_r + 8'h01;
    end
  end

  assign link_fwd_clk_out = fwd_clk_r;
  assign link_tx_bus_out = tx_bus_r;
  assign link_up_flag_out = link_up_r;
  assign peer_reset_irq_out = pr_irq_r;
  assign multibit_fault_irq_out = mb_irq_r;
  assign rev_irq_out = rev_irq_r;
  assign aclk_out = aclk_gen_r;
  assign m_axi_awid_out = awid_r;
  assign m_axi_awaddr_out = awaddr_r;
  assign m_axi_awvalid_out = awvalid_r;

endmodule

// [include/bridge_defs.vh]
// Shared constants of the chip link bridge ports block
`ifndef BRIDGE_DEFS_VH
`define BRIDGE_DEFS_VH

// Clock rates and derived cycle counts
`define CORE_CLK_PERIOD_NS 5
`define LINK_CLK_PERIOD_NS 80
`define LINK_HALF_CYC ((`LINK_CLK_PERIOD_NS / `CORE_CLK_PERIOD_NS) / 2)
`define ACLK_HALF_CYC 4
`define DESKEW_GOOD_CNT 16

// Link symbol layout
`define SYM_W 8
`define KIND_MSB 7
`define KIND_LSB 6
`define KIND_TRAIN 2'h0
`define KIND_STAT 2'h1
`define KIND_ASTART 2'h2
`define KIND_ANIB 2'h3
`define TRAIN_SEEK 8'h2a
`define TRAIN_ACK 8'h15
`define STAT_IRQ_MSB 3
`define STAT_IRQ_LSB 0
`define STAT_FAULT_BIT 4
`define STAT_BUSY_BIT 5
`define NIB_MSB 3
`define ID_MSB 5

// Write address assembly
`define ADDR_W 32
`define ADDR_NIBBLES 8
`define IRQ_W 4

// Link detect states, one-hot
`define ST_SEEK 4'h1
`define ST_DESKEW 4'h2
`define ST_ACK 4'h4
`define ST_SYNC 4'h8

`endif

// [design/link_rx_capture.v]
// Receive sampler: synchronises the peer's forwarded clock and data, captures on its rise
module link_rx_capture #(
  parameter PHY_W = 8
)(
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Link pins
  input wire fwd_clk_in,
  input wire [PHY_W-1:0] rx_bus_in,
  // Captured beat
  output wire [PHY_W-1:0] beat_out,
  output wire beat_stb_out
);

  reg clk_s1_r;
  reg clk_s2_r;
  reg clk_s3_r;
  reg [PHY_W-1:0] dat_s1_r;
  reg [PHY_W-1:0] dat_s2_r;
  reg [PHY_W-1:0] beat_r;
  reg stb_r;

  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      dat_s1_r <= {PHY_W{1'b0}};
      dat_s2_r <= {PHY_W{1'b0}};
      beat_r <= {PHY_W{1'b0}};
      stb_r <= 1'b0;
    end
    else
    begin
      clk_s1_r <= fwd_clk_in;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      dat_s1_r <= rx_bus_in;
      dat_s2_r <= dat_s1_r;
      // Data is captured on the peer clock's rising edge
      stb_r <= clk_s2_r & ~clk_s3_r;
      if (clk_s2_r & ~clk_s3_r)
      begin
        beat_r <= dat_s2_r;
      end
    end
  end

  assign beat_out = beat_r;
  assign beat_stb_out = stb_r;

endmodule

// [tb/bridge_port_sva.sv]
// Port assertions of the chip link bridge
module bridge_port_sva #(
  parameter PHY_W = 8,
  parameter ID_W = 6
)(
  input wire core_clk_in,
  input wire reset_n_in,
  input wire glob_rst_n_in,
  input wire link_fwd_clk_out,
  input wire [PHY_W-1:0] link_tx_bus_out,
  input wire link_up_flag_out,
  input wire peer_reset_irq_out,
  input wire peer_reset_clr_in,
  input wire [3:0] rev_irq_out,
  input wire aclk_out,
  input wire [ID_W-1:0] m_axi_awid_out,
  input wire [31:0] m_axi_awaddr_out,
  input wire m_axi_awvalid_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in || !glob_rst_n_in);

  sequence fwd_high_s;
    link_fwd_clk_out [*8] ##1 !link_fwd_clk_out;
  endsequence
  sequence aclk_high_s;
    aclk_out [*4] ##1 !aclk_out;
  endsequence

  reset_quiet_a: assert property (disable iff (!glob_rst_n_in)
    !reset_n_in |=> !link_up_flag_out && !link_fwd_clk_out && !m_axi_awvalid_out)
    else $error("output active in reset");
  fwd_half_a: assert property ($rose(link_fwd_clk_out) |-> fwd_high_s)
    else $error("link clock half period wrong");
  tx_on_fall_a: assert property ($changed(link_tx_bus_out) |-> $fell(link_fwd_clk_out))
    else $error("tx beat changed off clock fall");
  aclk_half_a: assert property ($rose(aclk_out) |-> aclk_high_s)
    else $error("interface clock half period wrong");
  aw_stable_a: assert property (
    m_axi_awvalid_out && $past(m_axi_awvalid_out)
    |-> $stable(m_axi_awaddr_out) && $stable(m_axi_awid_out))
    else $error("write address moved while valid");
  irq_sticky_a: assert property (
    peer_reset_irq_out && !peer_reset_clr_in |=> peer_reset_irq_out)
    else $error("peer reset irq lost");
  irq_link_drop_a: assert property ($rose(peer_reset_irq_out) |-> $fell(link_up_flag_out))
    else $error("peer reset irq without link drop");
  rev_quiet_a: assert property (!link_up_flag_out |-> rev_irq_out == 4'h0)
    else $error("irq levels while link down");
endmodule

bind axi_chip_link_bridge_ports bridge_port_sva #(.PHY_W(PHY_W), .ID_W(ID_W)) i_bridge_port_sva (
  .core_clk_in, .reset_n_in, .glob_rst_n_in, .link_fwd_clk_out, .link_tx_bus_out,
  .link_up_flag_out, .peer_reset_irq_out, .peer_reset_clr_in, .rev_irq_out, .aclk_out,
  .m_axi_awid_out, .m_axi_awaddr_out, .m_axi_awvalid_out);

// [tb/peer_link_model.sv]
// Far-end link model: forwards its clock and one symbol a beat
module peer_link_model #(
  parameter PHY_W = 8
)(
  output logic fwd_clk_out,
  output logic [PHY_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    fwd_clk_out = 1'b0;
    data_out = '0;
  end

  // Clock stands still between beats; data inverts once hold is over
  task automatic send(input logic [7:0] sym);
    data_out = PHY_W'(sym);
    #20 fwd_clk_out = 1'b1;
    #40 fwd_clk_out = 1'b0;
    #20 data_out = ~data_out;
  endtask
endmodule

// [tb/axi_chip_link_bridge_ports_tb.sv]
// Testbench of the chip link bridge ports
module axi_chip_link_bridge_ports_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic glob_rst_n_in = 1'b1;
  logic peer_reset_clr_in = 1'b0;
  logic m_axi_awready_in = 1'b0;
  logic [3:0] fwd_irq_in = 4'h0;
  wire link_fwd_clk_out, link_up_flag_out, peer_reset_irq_out, multibit_fault_irq_out;
  wire aclk_out, m_axi_awvalid_out, link_fwd_clk_in;
  wire [7:0] link_tx_bus_out, link_rx_bus_in;
  wire [3:0] rev_irq_out;
  wire [5:0] m_axi_awid_out;
  wire [31:0] m_axi_awaddr_out;
  int mismatches = 0;
  int check_count = 0;
  int st = 0;
  int good = 0;
  logic lfault = 1'b0;
  logic pfault = 1'b0;
  logic pirq = 1'b0;
  logic [3:0] rirq = 4'h0;
  logic [31:0] lfsr = 32'h17756;
  logic [37:0] aw_q[$];

  axi_chip_link_bridge_ports #(.DESKEW_GOOD(8'h04)) i_axi_chip_link_bridge_ports (
    .core_clk_in, .reset_n_in, .glob_rst_n_in, .link_fwd_clk_out, .link_tx_bus_out,
    .link_fwd_clk_in, .link_rx_bus_in, .link_up_flag_out, .peer_reset_irq_out,
    .peer_reset_clr_in, .multibit_fault_irq_out, .fwd_irq_in, .rev_irq_out,
    .aclk_in(aclk_out),
    .aclk_out, .m_axi_awid_out, .m_axi_awaddr_out, .m_axi_awvalid_out, .m_axi_awready_in);

  peer_link_model i_peer_link_model (.fwd_clk_out(link_fwd_clk_in), .data_out(link_rx_bus_in));

  initial
  begin
    // The 200 MHz core clock toggles every 2.5 ns
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic final_report();
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic await_valid(input logic lvl);
    int n = 0;
    while (m_axi_awvalid_out !== lvl && n < 400)
    begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 400)
    begin
      mismatches++;
      final_report();
    end
  endtask

  // Sends one beat and steps the reference link model
  task automatic beat(input logic [7:0] s);
    logic bad;
    bad = $countones(s ^ 8'h2a) > 1 && $countones(s ^ 8'h15) > 1;
    // Peer pins move off the core clock's rising edge
    @(negedge core_clk_in);
    i_peer_link_model.send(s);
    if (st == 3 && s == 8'h2a)
    begin
      st = 0;
      pirq = 1'b1;
    end
    else if (st == 0 && s == 8'h2a)
    begin
      st = 1;
      good = 0;
    end
    else if (st == 1 && s == 8'h2a)
    begin
      good++;
      st = (good == 4) ? 2 : 1;
    end
    else if (st == 1 && bad)
    begin
      st = 0;
      lfault = 1'b1;
    end
    else if (st == 2 && s == 8'h15)
    begin
      st = 3;
      lfault = 1'b0;
    end
    else if (st == 3 && s[7:6] == 2'b01)
    begin
      rirq = s[3:0];
      pfault = s[4];
    end
    // Irq levels and peer fault are dropped whenever the link is not up
    if (st != 3)
    begin
      rirq = 4'h0;
      pfault = 1'b0;
    end
    chk_bit(link_up_flag_out, st == 3, "link up");
    chk_word(32'(rev_irq_out), 32'(rirq), "rev irq");
    chk_bit(multibit_fault_irq_out, lfault | pfault, "multibit");
    chk_bit(peer_reset_irq_out, pirq, "peer reset");
  endtask

  task automatic train();
    repeat (5) beat(8'h2a);
    #400;
    chk_word(32'(link_tx_bus_out), 32'h15, "ack tx");
    beat(8'h15);
  endtask

  task automatic send_addr(input logic [5:0] id, input logic [31:0] a);
    logic [37:0] e;
    aw_q.push_back({id, a});
    beat({2'b10, id});
    for (int i = 7; i >= 0; i--)
      beat({4'hc, a[4*i+:4]});
    await_valid(1'b1);
    e = aw_q.pop_front();
    chk_word(m_axi_awaddr_out, e[31:0], "awaddr");
    chk_word(32'(m_axi_awid_out), 32'(e[37:32]), "awid");
    repeat (20) @(posedge core_clk_in);
    m_axi_awready_in <= 1'b1;
    await_valid(1'b0);
    m_axi_awready_in <= 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk_in);
    chk_bit(link_up_flag_out, 1'b0, "reset link");
    chk_word(32'(link_tx_bus_out), 32'h0, "reset tx");
    reset_n_in <= 1'b1;
    repeat (40) @(posedge core_clk_in);
    chk_word(32'(link_tx_bus_out), 32'h2a, "seek tx");
    @(negedge core_clk_in);
    beat(8'h2a);
    beat(8'hff);
    train();
    repeat (3)
    begin
      lfsr = nxt(lfsr);
      @(posedge core_clk_in);
      fwd_irq_in <= lfsr[11:8];
      @(negedge core_clk_in);
      beat({3'b010, lfsr[4:0]});
      #40;
      chk_word(32'(link_tx_bus_out), 32'({4'h4, lfsr[11:8]}), "irq tx");
    end
    beat(8'h40);
    repeat (2)
    begin
      lfsr = nxt(lfsr);
      send_addr(lfsr[5:0], nxt(lfsr));
    end
    @(negedge core_clk_in);
    beat(8'h2a);
    @(posedge core_clk_in);
    peer_reset_clr_in <= 1'b1;
    @(posedge core_clk_in);
    peer_reset_clr_in <= 1'b0;
    pirq = 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk_bit(peer_reset_irq_out, 1'b0, "irq clear");
    @(negedge core_clk_in);
    train();
    @(posedge core_clk_in);
    glob_rst_n_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    glob_rst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk_bit(link_up_flag_out, 1'b0, "global reset");
    final_report();
  end
endmodule
